// *** pkg/dsmap_pkg.sv ***
// Operation
// [R1] At 33 MHz each external memory access takes four bus clocks.
// [R2] Sync or async external memory supported, one type at a time.
// [R3] External memory data bus is 8 or 16 bits wide.
// [R4] External memory reached through external-data space, up to 24 bits.
// [R5] Code space is 64 KB and only main flash answers there.
// [R6] Lowest 32 internal bytes are four banks of eight working registers.
// [R7] The 16 bytes above the banks are also bit addressable.
// [R8] Direct accesses to the upper 128 bytes reach special registers.
// [R9] Indirect accesses to the upper 128 bytes reach upper RAM.
// [R10] Stack push and pop use the indirect path over all 256 bytes.
// [R11] Pointer choice picks which data pointer the pointer instructions use.
// [R12] Pointer-based external moves take top byte from that pointer's extension.
// [R13] Register-based external moves take top and middle bytes from extensions.
// [R14] Address extensions affect only external-data moves.
// [R15] High select bit: fast data drives pin; low: hub data drives it.
// [R16] Fast pin-state register is read-only and returns the pin levels.
// [R17] Fast port registers exist only for ports 0-6, 12 and 15.
// [R18] Port registers also reachable via hub, which owns boot setup.
// [R19] External-data space is decoded as 24 bits, 16 MB.
// [R20] Low external-data space decodes to SRAM, port control, ECC bytes.
// [R21] External-data 0x800000-0xFFFFFF goes to the external memory port.
// [R22] Pointer, choice and extension registers sit at fixed special addresses.
package dsmap_pkg;
   localparam logic [7:0] SFR_SP    = 8'h81;
   localparam logic [7:0] SFR_POINTER0_LOW_BYTE  = 8'h82;
   localparam logic [7:0] SFR_POINTER0_HIGH_BYTE  = 8'h83;
   localparam logic [7:0] SFR_POINTER1_LOW_BYTE  = 8'h84;
   localparam logic [7:0] SFR_POINTER1_HIGH_BYTE  = 8'h85;
   localparam logic [7:0] SFR_DPS   = 8'h86;
   localparam logic [7:0] SFR_POINTER0_TOP_BYTE  = 8'h93;
   localparam logic [7:0] SFR_POINTER1_TOP_BYTE  = 8'h95;
   localparam logic [7:0] SFR_MIDX  = 8'hA0;
   localparam logic [7:0] SFR_TOPX  = 8'hEA;
   localparam int FAST_PORTS = 9;
   // Port order 0,1,2,3,4,5,6,12,15 from the low byte up
   localparam logic [71:0] FAST_DATA_ADDRS = {8'hF8, 8'hE8, 8'hD8,
      8'hC8, 8'hC0, 8'hB0, 8'h98, 8'h90, 8'h80};
   localparam logic [71:0] FAST_PS_ADDRS = {8'hF9, 8'hE9, 8'hD9,
      8'hC9, 8'hC1, 8'hB1, 8'h99, 8'h91, 8'h89};
   localparam logic [71:0] FAST_SEL_ADDRS = {8'hFA, 8'hF2, 8'hDA,
      8'hCA, 8'hC2, 8'hB2, 8'h9A, 8'hA2, 8'h8A};
   localparam logic [7:0] SP_RESET  = 8'h07;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] BIT_AREA_HI = 4'h2;
   localparam logic [23:0] SRAM_END     = 24'h001FFF;
   localparam logic [23:0] EMICTL_BASE  = 24'h005400;
   localparam logic [23:0] EMICTL_END   = 24'h0054FF;
   localparam logic [23:0] ECC_BASE     = 24'h080000;
   localparam logic [23:0] ECC_END      = 24'h081FFF;
   localparam logic [23:0] EXTMEM_BASE  = 24'h800000;
   localparam int EMI_ACCESS_CYCLES = 4;
   typedef enum logic [2:0] {
      DM_DIRECT   = 3'b000,
      DM_INDIRECT = 3'b001,
      DM_REGISTER = 3'b010,
      DM_BIT      = 3'b011,
      DM_PUSH     = 3'b100,
      DM_POP      = 3'b101
   } dmode_e;
   typedef enum logic [1:0] {
      PO_NONE = 2'b00,
      PO_INC  = 2'b01,
      PO_LOAD = 2'b10
   } ptr_op_e;
   typedef enum logic [2:0] {
      XR_SRAM   = 3'b000,
      XR_EMICTL = 3'b001,
      XR_ECC    = 3'b010,
      XR_EXT    = 3'b011,
      XR_HUB    = 3'b100
   } xregion_e;
   typedef enum logic [1:0] {
      XS_IDLE   = 2'b00,
      XS_ONCHIP = 2'b01,
      XS_EXT    = 2'b10
   } xstate_e;
endpackage

// *** core/cpu_data_space_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_data_space_map
   import dsmap_pkg::*;
#(
   parameter int ACCESS_CYCLES = EMI_ACCESS_CYCLES
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        C_REQ,
   input  wire logic [15:0] C_ADDR,
   output logic             FLASH_REQ,
   output logic [15:0]      FLASH_ADDR,
   input  wire logic        D_REQ,
   input  wire logic [2:0]  D_MODE,
   input  wire logic        D_WE,
   input  wire logic [7:0]  D_ADDR,
   input  wire logic [7:0]  D_WDATA,
   input  wire logic [1:0]  D_BANK,
   output logic             D_ACK,
   output logic [7:0]       D_RDATA,
   output logic             D_CORE_SFR,
   input  wire logic [1:0]  P_OP,
   input  wire logic [15:0] P_LOAD,
   output logic [15:0]      DPTR_CUR,
   input  wire logic        X_REQ,
   input  wire logic        X_WE,
   input  wire logic        X_VIA_REG,
   input  wire logic [7:0]  X_LOW,
   input  wire logic [7:0]  X_WDATA,
   input  wire logic [7:0]  X_ONCHIP_RDATA,
   output logic             X_BUSY,
   output logic             X_ACK,
   output logic [7:0]       X_RDATA,
   output logic             X_STB,
   output logic             X_WE_OUT,
   output logic [7:0]       X_WDATA_OUT,
   output logic [23:0]      X_ADDR,
   output logic [2:0]       X_REGION,
   input  wire logic        EMI_SYNC_CFG,
   input  wire logic        EMI_WIDE_CFG,
   input  wire logic [15:0] EMI_RDATA,
   output logic             EMI_SYNC,
   output logic             EMI_WIDE,
   output logic             EMI_REQ,
   output logic             EMI_WE,
   output logic [23:0]      EMI_ADDR,
   output logic [1:0]       EMI_BYTE_EN,
   output logic [15:0]      EMI_WDATA,
   input  wire logic [71:0] PORT_HUB_DATA,
   input  wire logic [71:0] PORT_PINS,
   output logic [71:0]      PORT_DRIVE
);

   logic [7:0]  iram [0:255];
   logic [7:0]  sp;
   logic [7:0]  pointer_choice;
   logic [15:0] dptr [0:1];
   logic [7:0]  dpx [0:1];
   logic [7:0]  mid_ext;
   logic [7:0]  top_ext;
   logic [71:0] fast_data;
   logic [71:0] fast_sel;
   logic        cfg_taken;
   xstate_e     xstate;
   logic [2:0]  cnt;

   // Internal data address formation
   wire        is_reg   = D_MODE == DM_REGISTER;
   wire        is_bit   = D_MODE == DM_BIT;
   wire        is_push  = D_MODE == DM_PUSH;
   wire        is_pop   = D_MODE == DM_POP;
   wire [7:0]  reg_addr = {3'b000, D_BANK, D_ADDR[2:0]}; // see [R6]
   wire [7:0]  bit_addr = D_ADDR[7] ? {D_ADDR[7:3], 3'b000}
                                    : {BIT_AREA_HI, D_ADDR[6:3]}; // see [R7]
   wire [7:0]  sp_inc   = sp + 8'h01;
   wire [7:0]  eff_addr = is_reg  ? reg_addr :
                          is_bit  ? bit_addr :
                          is_push ? sp_inc   :
                          is_pop  ? sp       : D_ADDR; // see [R10]
   // Only direct and bit modes can reach the special registers
   wire        is_sfr   = D_ADDR[7] &&
                          (D_MODE == DM_DIRECT || is_bit); // see [R8] [R9]
   wire [2:0]  bit_pos  = D_ADDR[2:0];

   logic [FAST_PORTS-1:0] data_hit;
   logic [FAST_PORTS-1:0] ps_hit;
   logic [FAST_PORTS-1:0] sel_hit;
   genvar g;
   generate
      for (g = 0; g < FAST_PORTS; g++) begin : g_hit
         assign data_hit[g] = eff_addr == FAST_DATA_ADDRS[g*8 +: 8]; // see [R17]
         assign ps_hit[g]   = eff_addr == FAST_PS_ADDRS[g*8 +: 8];
         assign sel_hit[g]  = eff_addr == FAST_SEL_ADDRS[g*8 +: 8];
      end
   endgenerate

   logic [7:0] sfr_rd;
   logic       sfr_owned;
   always_comb begin
      sfr_rd    = 8'h00;
      sfr_owned = 1'b1;
      unique case (eff_addr) // see [R22]
         SFR_SP:   sfr_rd = sp;
         SFR_POINTER0_LOW_BYTE: sfr_rd = dptr[0][7:0];
         SFR_POINTER0_HIGH_BYTE: sfr_rd = dptr[0][15:8];
         SFR_POINTER1_LOW_BYTE: sfr_rd = dptr[1][7:0];
         SFR_POINTER1_HIGH_BYTE: sfr_rd = dptr[1][15:8];
         SFR_DPS:  sfr_rd = pointer_choice;
         SFR_POINTER0_TOP_BYTE: sfr_rd = dpx[0];
         SFR_POINTER1_TOP_BYTE: sfr_rd = dpx[1];
         SFR_MIDX: sfr_rd = mid_ext;
         SFR_TOPX: sfr_rd = top_ext;
         default:  sfr_owned = 1'b0;
      endcase
      for (int i = 0; i < FAST_PORTS; i++) begin
         if (data_hit[i]) begin
            sfr_rd    = fast_data[i*8 +: 8];
            sfr_owned = 1'b1;
         end
         if (ps_hit[i]) begin
            sfr_rd    = PORT_PINS[i*8 +: 8]; // see [R16]
            sfr_owned = 1'b1;
         end
         if (sel_hit[i]) begin
            sfr_rd    = fast_sel[i*8 +: 8];
            sfr_owned = 1'b1;
         end
      end
   end

   wire [7:0] byte_rd  = is_sfr ? sfr_rd : iram[eff_addr];
   wire [7:0] bit_mask = 8'h01 << bit_pos;
   wire [7:0] bit_merge = D_WDATA[0] ? (byte_rd | bit_mask)
                                     : (byte_rd & ~bit_mask); // see [R7]
   wire [7:0] wr_byte  = is_bit ? bit_merge : D_WDATA;
   wire       do_write = D_REQ && !is_pop && (D_WE || is_push);
   wire       ram_we   = do_write && !is_sfr;
   // Pin-state addresses take no write; the core owns unknown addresses
   wire       sfr_we   = do_write && is_sfr && sfr_owned;
   wire [7:0] rd_value = is_bit ? {7'h00, byte_rd[bit_pos]} : byte_rd;

   always_ff @(posedge CLK) begin
      if (ram_we)
         iram[eff_addr] <= wr_byte; // see [R9] [R10]
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         D_ACK      <= 1'b0;
         D_RDATA    <= REG_RESET;
         D_CORE_SFR <= 1'b0;
      end else begin
         D_ACK      <= D_REQ;
         D_RDATA    <= rd_value;
         D_CORE_SFR <= D_REQ && is_sfr && !sfr_owned; // see [R8]
      end
   end

   // Stack pointer: push pre-increments, pop post-decrements
   always_ff @(posedge CLK or posedge RST) begin
      if (RST)
         sp <= SP_RESET;
      else if (D_REQ && is_push)
         sp <= sp_inc; // see [R10]
      else if (D_REQ && is_pop)
         sp <= sp - 8'h01;
      else if (sfr_we && eff_addr == SFR_SP)
         sp <= wr_byte;
   end

   wire       psel   = pointer_choice[0]; // see [R11]
   wire       p_inc  = P_OP == PO_INC;
   wire       p_load = P_OP == PO_LOAD;

   generate
      for (g = 0; g < 2; g++) begin : g_ptr
         wire [7:0] lo_a = g ? SFR_POINTER1_LOW_BYTE : SFR_POINTER0_LOW_BYTE;
         wire [7:0] hi_a = g ? SFR_POINTER1_HIGH_BYTE : SFR_POINTER0_HIGH_BYTE;
         wire [7:0] x_a  = g ? SFR_POINTER1_TOP_BYTE : SFR_POINTER0_TOP_BYTE;
         wire       mine = psel == g[0];
         // Pointer instructions leave the extension byte alone
         always_ff @(posedge CLK or posedge RST) begin
            if (RST)
               dptr[g] <= {REG_RESET, REG_RESET};
            else if (mine && p_load)
               dptr[g] <= P_LOAD; // see [R11] [R14]
            else if (mine && p_inc)
               dptr[g] <= dptr[g] + 16'h0001; // see [R11] [R14]
            else if (sfr_we && eff_addr == lo_a)
               dptr[g][7:0] <= wr_byte;
            else if (sfr_we && eff_addr == hi_a)
               dptr[g][15:8] <= wr_byte;
         end
         always_ff @(posedge CLK or posedge RST) begin
            if (RST)
               dpx[g] <= REG_RESET;
            else if (sfr_we && eff_addr == x_a)
               dpx[g] <= wr_byte; // see [R22]
         end
      end
   endgenerate

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pointer_choice     <= REG_RESET;
         mid_ext <= REG_RESET;
         top_ext <= REG_RESET;
      end else begin
         if (sfr_we && eff_addr == SFR_DPS)
            pointer_choice <= wr_byte; // see [R22]
         if (sfr_we && eff_addr == SFR_MIDX)
            mid_ext <= wr_byte;
         if (sfr_we && eff_addr == SFR_TOPX)
            top_ext <= wr_byte;
      end
   end

   // One cycle behind the pointer registers, for table reads and jumps
   always_ff @(posedge CLK or posedge RST) begin
      if (RST)
         DPTR_CUR <= {REG_RESET, REG_RESET};
      else
         DPTR_CUR <= dptr[psel]; // see [R11] [R14]
   end

   // Select resets low so the hub path owns the pins through boot
   generate
      for (g = 0; g < FAST_PORTS; g++) begin : g_port
         always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
               fast_data[g*8 +: 8] <= REG_RESET;
               fast_sel[g*8 +: 8]  <= REG_RESET; // see [R18]
            end else begin
               if (sfr_we && data_hit[g])
                  fast_data[g*8 +: 8] <= wr_byte;
               if (sfr_we && sel_hit[g])
                  fast_sel[g*8 +: 8] <= wr_byte;
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK or posedge RST) begin
      if (RST)
         PORT_DRIVE <= {9{REG_RESET}};
      else
         PORT_DRIVE <= (fast_sel & fast_data) |
                       (~fast_sel & PORT_HUB_DATA); // see [R15] [R18]
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         FLASH_REQ  <= 1'b0;
         FLASH_ADDR <= {REG_RESET, REG_RESET};
      end else begin
         FLASH_REQ  <= C_REQ; // see [R5]
         FLASH_ADDR <= C_ADDR;
      end
   end

   function automatic xregion_e region_of(input logic [23:0] a);
      if (a >= EXTMEM_BASE)
         return XR_EXT; // see [R21]
      else if (a <= SRAM_END)
         return XR_SRAM; // see [R20]
      else if (a >= EMICTL_BASE && a <= EMICTL_END)
         return XR_EMICTL;
      else if (a >= ECC_BASE && a <= ECC_END)
         return XR_ECC;
      else
         return XR_HUB;
   endfunction

   // Extensions feed only this path, never code or internal data
   wire [23:0] x_addr = X_VIA_REG ? {top_ext, mid_ext, X_LOW} // see [R13]
                                  : {dpx[psel], dptr[psel]}; // see [R12] [R19]
   wire        x_take = X_REQ && xstate == XS_IDLE;
   xregion_e   x_reg;
   assign x_reg = region_of(x_addr);
   wire        x_last = cnt == 3'(ACCESS_CYCLES - 1);
   wire [7:0]  emi_lane = (EMI_WIDE && X_ADDR[0]) ? EMI_RDATA[15:8]
                                                  : EMI_RDATA[7:0]; // see [R3]

   // Memory type and width are caught once after reset and then held
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg_taken <= 1'b0;
         EMI_SYNC  <= 1'b0;
         EMI_WIDE  <= 1'b0;
      end else if (!cfg_taken) begin
         cfg_taken <= 1'b1;
         EMI_SYNC  <= EMI_SYNC_CFG; // see [R2]
         EMI_WIDE  <= EMI_WIDE_CFG; // see [R3]
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         X_ADDR      <= 24'h000000;
         X_REGION    <= XR_SRAM;
         X_WE_OUT    <= 1'b0;
         X_WDATA_OUT <= REG_RESET;
         EMI_ADDR    <= 24'h000000;
         EMI_BYTE_EN <= 2'b00;
         EMI_WDATA   <= {REG_RESET, REG_RESET};
         EMI_WE      <= 1'b0;
      end else if (x_take) begin
         X_ADDR      <= x_addr; // see [R4]
         X_REGION    <= x_reg;
         X_WE_OUT    <= X_WE;
         X_WDATA_OUT <= X_WDATA;
         EMI_ADDR    <= EMI_WIDE ? {1'b0, x_addr[23:1]} : x_addr;
         EMI_BYTE_EN <= !EMI_WIDE ? 2'b01 :
                        x_addr[0] ? 2'b10 : 2'b01; // see [R3]
         EMI_WDATA   <= {X_WDATA, X_WDATA};
         EMI_WE      <= X_WE;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         xstate  <= XS_IDLE;
         cnt     <= 3'b000;
         X_BUSY  <= 1'b0;
         X_ACK   <= 1'b0;
         X_STB   <= 1'b0;
         X_RDATA <= REG_RESET;
         EMI_REQ <= 1'b0;
      end else begin
         X_ACK <= 1'b0;
         X_STB <= 1'b0;
         unique case (xstate)
            XS_IDLE: if (X_REQ) begin
               X_BUSY <= 1'b1;
               cnt    <= 3'b000;
               if (x_reg == XR_EXT) begin
                  xstate  <= XS_EXT;
                  EMI_REQ <= 1'b1; // see [R21]
               end else begin
                  xstate <= XS_ONCHIP;
                  X_STB  <= 1'b1; // see [R20]
               end
            end
            XS_ONCHIP: begin
               xstate  <= XS_IDLE;
               X_BUSY  <= 1'b0;
               X_ACK   <= 1'b1;
               X_RDATA <= X_ONCHIP_RDATA;
            end
            XS_EXT: begin
               cnt <= cnt + 3'b001;
               if (x_last) begin
                  xstate  <= XS_IDLE;
                  EMI_REQ <= 1'b0; // see [R1]
                  X_BUSY  <= 1'b0;
                  X_ACK   <= 1'b1;
                  X_RDATA <= emi_lane;
               end
            end
            default: xstate <= XS_IDLE;
         endcase
      end
   end

   property p_emi_len;
      @(posedge CLK) disable iff (RST)
      $rose(EMI_REQ) |-> EMI_REQ [*4] ##1 !EMI_REQ;
   endproperty
   a_emi_len: assert property (p_emi_len) // see [R1]
      else $error("external access not four cycles");

   property p_ext_ack;
      @(posedge CLK) disable iff (RST)
      $rose(EMI_REQ) |-> !X_ACK [*4] ##1 (X_ACK && X_ADDR[23]);
   endproperty
   a_ext_ack: assert property (p_ext_ack) // see [R21]
      else $error("external answer late or off window");

   property p_onchip;
      @(posedge CLK) disable iff (RST)
      X_STB |-> !X_ADDR[23] && X_REGION != XR_EXT ##1 X_ACK;
   endproperty
   a_onchip: assert property (p_onchip) // see [R20]
      else $error("on-chip strobe misrouted");

   property p_type_held;
      @(posedge CLK) disable iff (RST)
      cfg_taken && $past(cfg_taken) |-> $stable(EMI_SYNC) && $stable(EMI_WIDE);
   endproperty
   a_type_held: assert property (p_type_held) // see [R2]
      else $error("memory type changed after start");

   property p_narrow;
      @(posedge CLK) disable iff (RST)
      EMI_REQ && !EMI_WIDE |-> EMI_BYTE_EN == 2'b01 && EMI_ADDR == X_ADDR;
   endproperty
   a_narrow: assert property (p_narrow) // see [R3]
      else $error("narrow bus lane wrong");

   property p_upper_ind;
      @(posedge CLK) disable iff (RST)
      D_REQ && D_MODE == DM_INDIRECT && D_WE && D_ADDR[7]
      |=> iram[$past(D_ADDR)] == $past(D_WDATA);
   endproperty
   a_upper_ind: assert property (p_upper_ind) // see [R9]
      else $error("indirect upper write missed RAM");

   property p_dps_direct;
      @(posedge CLK) disable iff (RST)
      D_REQ && D_MODE == DM_DIRECT && D_WE && D_ADDR == SFR_DPS
      |=> pointer_choice == $past(D_WDATA) ##1 D_RDATA == D_RDATA;
   endproperty
   a_dps_direct: assert property (p_dps_direct) // see [R8]
      else $error("direct write missed select register");

   property p_push;
      @(posedge CLK) disable iff (RST)
      D_REQ && D_MODE == DM_PUSH
      |=> sp == $past(sp) + 8'h01 && iram[sp] == $past(D_WDATA);
   endproperty
   a_push: assert property (p_push) // see [R10]
      else $error("push did not land above stack top");

   property p_drive;
      @(posedge CLK) disable iff (RST)
      1'b1 |=> PORT_DRIVE == (($past(fast_sel) & $past(fast_data)) |
                              (~$past(fast_sel) & $past(PORT_HUB_DATA)));
   endproperty
   a_drive: assert property (p_drive) // see [R15]
      else $error("pin drive source wrong");

   property p_pins;
      @(posedge CLK) disable iff (RST)
      D_REQ && D_MODE == DM_DIRECT && D_ADDR == FAST_PS_ADDRS[7:0]
      |=> D_RDATA == $past(PORT_PINS[7:0]);
   endproperty
   a_pins: assert property (p_pins) // see [R16]
      else $error("pin state read wrong");

   property p_reg_path;
      @(posedge CLK) disable iff (RST)
      x_take && X_VIA_REG
      |=> X_ADDR == {$past(top_ext), $past(mid_ext), $past(X_LOW)};
   endproperty
   a_reg_path: assert property (p_reg_path) // see [R13]
      else $error("register-based address wrong");

endmodule
`default_nettype wire

// *** tb/far_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        emi_req,
   input  wire logic [23:0] emi_addr,
   input  wire logic        x_stb,
   input  wire logic [23:0] x_addr,
   output logic [15:0]      emi_rdata,
   output logic [7:0]       onchip_rdata
);
   logic [7:0] churn;

   // Idle buses move every cycle so stale data never passes for an answer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) churn <= 8'h00;
      else churn <= churn + 8'h5B;
   end
   assign emi_rdata = emi_req ? {emi_addr[7:0] ^ 8'h5A, emi_addr[7:0]}
                              : {churn, ~churn};
   assign onchip_rdata = x_stb ? (x_addr[7:0] ^ 8'h3C) : churn;
endmodule
`default_nettype wire

// *** tb/cpu_data_space_mapping_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_data_space_mapping_test import dsmap_pkg::*;;
   logic clk = 0, rst = 1, c_req = 0, d_req = 0, d_we = 0, x_req = 0;
   logic x_we = 0, x_reg = 0, cf, flash_req, d_ack, d_core, x_busy, x_ack;
   logic x_stb, x_we_o, emi_sync, emi_wide, emi_req, emi_we;
   logic [15:0] c_addr = 0, p_load = 0, flash_addr, dptr, emi_rd, emi_wd;
   logic [7:0]  d_addr = 0, d_wdata = 0, x_low = 0, x_wdata = 0, rd;
   logic [7:0]  d_rdata, x_rdata, x_wd_o, x_on_rd;
   logic [2:0]  d_mode = 0, x_region;
   logic [1:0]  d_bank = 0, p_op = 0, emi_be;
   logic [23:0] x_addr, emi_addr;
   logic [71:0] hub = 72'h5AA53CC396690FF0AA, pins = 72'h0, drive;
   int          errors = 0, compares = 0;

   always #4 clk = ~clk;

   cpu_data_space_map #(.ACCESS_CYCLES(4)) dut (.CLK(clk), .RST(rst),
      .C_REQ(c_req), .C_ADDR(c_addr), .FLASH_REQ(flash_req),
      .FLASH_ADDR(flash_addr), .D_REQ(d_req), .D_MODE(d_mode), .D_WE(d_we),
      .D_ADDR(d_addr), .D_WDATA(d_wdata), .D_BANK(d_bank), .D_ACK(d_ack),
      .D_RDATA(d_rdata), .D_CORE_SFR(d_core), .P_OP(p_op), .P_LOAD(p_load),
      .DPTR_CUR(dptr), .X_REQ(x_req), .X_WE(x_we), .X_VIA_REG(x_reg),
      .X_LOW(x_low), .X_WDATA(x_wdata), .X_ONCHIP_RDATA(x_on_rd),
      .X_BUSY(x_busy), .X_ACK(x_ack), .X_RDATA(x_rdata), .X_STB(x_stb),
      .X_WE_OUT(x_we_o), .X_WDATA_OUT(x_wd_o), .X_ADDR(x_addr),
      .X_REGION(x_region), .EMI_SYNC_CFG(1'b1), .EMI_WIDE_CFG(1'b1),
      .EMI_RDATA(emi_rd), .EMI_SYNC(emi_sync), .EMI_WIDE(emi_wide),
      .EMI_REQ(emi_req), .EMI_WE(emi_we), .EMI_ADDR(emi_addr),
      .EMI_BYTE_EN(emi_be), .EMI_WDATA(emi_wd), .PORT_HUB_DATA(hub),
      .PORT_PINS(pins), .PORT_DRIVE(drive));

   far_side_model far (.clk(clk), .rst(rst), .emi_req(emi_req),
      .emi_addr(emi_addr), .x_stb(x_stb), .x_addr(x_addr),
      .emi_rdata(emi_rd), .onchip_rdata(x_on_rd));

   task automatic chk(input string nm, input logic [23:0] e,
                      input logic [23:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic close_out;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic d_acc(input logic [2:0] m, input logic w,
                        input logic [7:0] a, input logic [7:0] v,
                        input logic [1:0] b);
      @(posedge clk);
      d_req <= 1'b1; d_mode <= m; d_we <= w;
      d_addr <= a; d_wdata <= v; d_bank <= b;
      @(posedge clk);
      d_req <= 1'b0;
      #1;
      rd = d_rdata;
      cf = d_core;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      d_acc(DM_DIRECT, 1'b1, a, v, 2'd0);
   endtask

   task automatic rdck(input logic [2:0] m, input logic [7:0] a,
                       input logic [7:0] e);
      d_acc(m, 1'b0, a, 8'h00, 2'd0);
      chk("d_rdata", e, rd);
   endtask

   task automatic x_acc(input logic via, input logic [23:0] a,
                        input logic [2:0] rg);
      int n;
      logic [23:0] ea;
      logic [7:0] er;
      n = 0;
      ea = 0;
      er = (rg == XR_EXT) ? (a[0] ? a[8:1] ^ 8'h5A : a[8:1])
                          : a[7:0] ^ 8'h3C;
      @(posedge clk);
      x_req <= 1'b1; x_reg <= via; x_low <= a[7:0];
      @(posedge clk);
      x_req <= 1'b0;
      repeat (10) begin
         #1;
         if (emi_req === 1'b1) begin
            n++;
            ea = emi_addr;
         end
         if (x_ack === 1'b1) break;
         @(posedge clk);
      end
      chk("x_ack", 1'b1, x_ack);
      chk("x_addr", a, x_addr);
      chk("x_region", rg, x_region);
      chk("emi cycles", (rg == XR_EXT) ? 4 : 0, n);
      chk("x_rdata", er, x_rdata);
      if (rg == XR_EXT) chk("emi_addr", a >> 1, ea);
   endtask

   task automatic ptr_op(input logic [1:0] op, input logic [15:0] ld,
                         input logic [15:0] e);
      @(posedge clk);
      p_op <= op; p_load <= ld;
      @(posedge clk);
      p_op <= 2'd0;
      @(posedge clk);
      #1;
      chk("dptr", e, dptr);
   endtask

   task automatic t_reset;
      rdck(DM_DIRECT, SFR_SP, SP_RESET);
      rdck(DM_DIRECT, SFR_DPS, REG_RESET);
      chk("emi type", 2'b11, {emi_sync, emi_wide});
      @(posedge clk);
      c_req <= 1'b1; c_addr <= 16'hFFFF;
      @(posedge clk);
      c_req <= 1'b0;
      #1;
      chk("flash", 17'h1FFFF, {flash_req, flash_addr});
   endtask

   task automatic t_pointers;
      logic [7:0] ad [8] = '{SFR_POINTER0_LOW_BYTE, SFR_POINTER0_HIGH_BYTE, SFR_POINTER1_LOW_BYTE, SFR_POINTER1_HIGH_BYTE,
                             SFR_POINTER0_TOP_BYTE, SFR_POINTER1_TOP_BYTE, SFR_MIDX, SFR_TOPX};
      for (int i = 0; i < 8; i++) wr(ad[i], 8'h31 + i[7:0]);
      for (int i = 0; i < 8; i++) rdck(DM_DIRECT, ad[i], 8'h31 + i[7:0]);
      wr(SFR_DPS, 8'h01);
      ptr_op(2'd0, 16'h0, 16'h3433);
      ptr_op(2'd1, 16'h0, 16'h3434);
      rdck(DM_DIRECT, SFR_POINTER0_LOW_BYTE, 8'h31);
      ptr_op(2'd2, 16'hFFFF, 16'hFFFF);
      ptr_op(2'd1, 16'h0, 16'h0000);
      rdck(DM_DIRECT, SFR_POINTER1_TOP_BYTE, 8'h36);
      wr(SFR_DPS, 8'h00);
      ptr_op(2'd0, 16'h0, 16'h3231);
   endtask

   task automatic t_iram;
      for (int b = 0; b < 4; b++) d_acc(DM_REGISTER, 1'b1, b[7:0], 8'hC0 + b[7:0], b[1:0]);
      for (int b = 0; b < 4; b++) rdck(DM_INDIRECT, 8'h09 * b[7:0], 8'hC0 + b[7:0]);
      d_acc(DM_INDIRECT, 1'b1, 8'h21, 8'h00, 2'd0);
      d_acc(DM_BIT, 1'b1, 8'h0A, 8'h01, 2'd0);
      rdck(DM_INDIRECT, 8'h21, 8'h04);
      d_acc(DM_BIT, 1'b0, 8'h0A, 8'h00, 2'd0);
      chk("bit", 1'b1, rd[0]);
      d_acc(DM_INDIRECT, 1'b1, 8'h90, 8'h5E, 2'd0);
      wr(8'h90, 8'h11);
      rdck(DM_INDIRECT, 8'h90, 8'h5E);
      rdck(DM_DIRECT, 8'h90, 8'h11);
      wr(SFR_SP, 8'hFE);
      d_acc(DM_PUSH, 1'b1, 8'h00, 8'h77, 2'd0);
      rdck(DM_INDIRECT, 8'hFF, 8'h77);
      d_acc(DM_POP, 1'b0, 8'h00, 8'h00, 2'd0);
      chk("pop", 8'h77, rd);
      rdck(DM_DIRECT, SFR_SP, 8'hFE);
   endtask

   task automatic t_ports;
      logic [7:0] s, h;
      pins = ~hub;
      for (int k = 0; k < FAST_PORTS; k++) begin
         s = 8'h0F + k[7:0];
         h = hub[8*k+:8];
         wr(FAST_DATA_ADDRS[8*k+:8], 8'hF0);
         wr(FAST_SEL_ADDRS[8*k+:8], s);
         wr(FAST_PS_ADDRS[8*k+:8], 8'h00);
         @(posedge clk);
         #1;
         chk("drive", (8'hF0 & s) | (h & ~s), drive[8*k+:8]);
         rdck(DM_DIRECT, FAST_PS_ADDRS[8*k+:8], ~h);
      end
      wr(8'hB8, 8'h55);
      chk("core", 1'b1, cf);
   endtask

   task automatic t_xdata;
      logic [23:0] av [9] = '{24'h001FFF, 24'h002000, 24'h005400,
         24'h0054FF, 24'h080000, 24'h081FFF, 24'h7FFFFF, 24'h800001,
         24'hFFFFFE};
      logic [2:0] rv [9] = '{XR_SRAM, XR_HUB, XR_EMICTL, XR_EMICTL,
         XR_ECC, XR_ECC, XR_HUB, XR_EXT, XR_EXT};
      for (int i = 0; i < 9; i++) begin
         wr(SFR_POINTER0_TOP_BYTE, av[i][23:16]);
         wr(SFR_POINTER0_HIGH_BYTE, av[i][15:8]);
         wr(SFR_POINTER0_LOW_BYTE, av[i][7:0]);
         x_acc(1'b0, av[i], rv[i]);
      end
      wr(SFR_TOPX, 8'h80);
      wr(SFR_MIDX, 8'h12);
      x_acc(1'b1, 24'h801234, XR_EXT);
      wr(SFR_TOPX, 8'h00);
      wr(SFR_MIDX, 8'h54);
      x_acc(1'b1, 24'h005410, XR_EMICTL);
   endtask

   // Bound is about sixty times the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out;
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset;
      t_pointers;
      t_iram;
      t_ports;
      t_xdata;
      close_out;
   end
endmodule
`default_nettype wire
